// ---- hdl/fdc_ctrl.v ----
// FIFO DRAM controller datapath: strobes, pointers, address, status.
// Assumes a 64K x N DRAM on the pins and active-low request pins.
//
// Overview of operation
// - RAS from settable flop, ORed next term
// - Secondary access flag cleared with RAS
// - Read pointer: 16-bit counter with carries
// - Read select picks read pointer, else write
// - Row then column part, registered to pins
// - Status bits step per access with carries
// - System clock and separate refresh request
// - Count up on write, down on read
// - Full, half-full, empty flags active high
// - Row is low byte, column high byte
// - Refresh: CAS edge one, RAS two, release
`timescale 1ns/1ps
`include "fdc_map.vh"

module fdc_ctrl (
    input wire mclk,
    input wire reset_n,
    input wire init_clr,
    input wire req_wr_n,
    input wire req_rd_n,
    input wire refresh_enable_req_n,
    output reg ras_n_r,
    output reg cas_n_r,
    output reg we_n_r,
    output reg oe_n_r,
    output reg [7:0] dram_addr_r,
    output wire rdy_wr,
    output wire rdy_rd,
    output wire flag_full,
    output wire flag_half,
    output wire flag_empty
);

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    reg [2:0] sync1_r;
    reg [2:0] sync2_r;
    reg refresh_enable_prev_r;

    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sync1_r <= 3'h7;
            sync2_r <= 3'h7;
            refresh_enable_prev_r <= `FDC_ONE;
        end else begin
            sync1_r <= {refresh_enable_req_n, req_rd_n, req_wr_n};
            sync2_r <= sync1_r;
            refresh_enable_prev_r <= sync2_r[2];
        end
    end

    wire wr_req = ~sync2_r[0];
    wire rd_req = ~sync2_r[1];
    // Refresh clock runs free; one request per falling edge
    wire refresh_enable_edge = refresh_enable_prev_r & ~sync2_r[2];

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    reg [2:0] state_r;
    reg [2:0] state_nxt;
    reg refresh_enable_pend_r;
    reg access_enable_secondary_r;
    reg wr_sel_r;
    reg rd_sel_r;
    reg row_col_sel_r;

    wire [15:0] read_ptr;
    wire [15:0] write_ptr;
    wire [15:0] status_cnt;

    wire idle = (state_r == `FDC_S_IDLE);
    wire can_wr = wr_req & ~flag_full;
    wire can_rd = rd_req & ~flag_empty;
    wire refresh_enable_go = refresh_enable_pend_r | refresh_enable_edge;

    always @* begin
        case (state_r)
            `FDC_S_IDLE: begin
                // Refresh first, then write, then read
                if (refresh_enable_go) begin
                    state_nxt = `FDC_S_RCAS;
                end else if (can_wr | can_rd) begin
                    state_nxt = `FDC_S_AROW;
                end else begin
                    state_nxt = `FDC_S_IDLE;
                end
            end
            `FDC_S_AROW: state_nxt = `FDC_S_ARAS;
            `FDC_S_ARAS: state_nxt = `FDC_S_ACOL;
            `FDC_S_ACOL: state_nxt = `FDC_S_AEND;
            `FDC_S_RCAS: state_nxt = `FDC_S_RRAS;
            `FDC_S_RRAS: state_nxt = `FDC_S_REND;
            default: state_nxt = `FDC_S_IDLE;
        endcase
    end

    wire acc_start = idle & ~refresh_enable_go & (can_wr | can_rd);
    wire acc_done = (state_r == `FDC_S_AEND);

    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= `FDC_S_IDLE;
            refresh_enable_pend_r <= `FDC_ZERO;
            wr_sel_r <= `FDC_ZERO;
            rd_sel_r <= `FDC_ZERO;
        end else if (init_clr) begin
            state_r <= `FDC_S_IDLE;
            refresh_enable_pend_r <= `FDC_ZERO;
            wr_sel_r <= `FDC_ZERO;
            rd_sel_r <= `FDC_ZERO;
        end else begin
            state_r <= state_nxt;
            // Edge during a busy cycle waits, never lost
            if (refresh_enable_edge & ~idle) begin
                refresh_enable_pend_r <= `FDC_ONE;
            end else if (idle) begin
                refresh_enable_pend_r <= `FDC_ZERO;
            end
            if (acc_start) begin
                wr_sel_r <= can_wr;
                rd_sel_r <= ~can_wr;
            end else if (acc_done) begin
                wr_sel_r <= `FDC_ZERO;
                rd_sel_r <= `FDC_ZERO;
            end
        end
    end

    // ----------------------------------------
    // RAS, CAS and row/column select
    // ----------------------------------------
    wire ras_act = ~ras_n_r;
    wire cas_act = ~cas_n_r;
    // Four-input term: next state ARAS, RAS idle, row select high, CAS idle
    // RAS and CAS must leave together, so no term holds RAS past column
    wire row_strobe_comb_term = ~((state_nxt == `FDC_S_ARAS) & ~ras_act &
        row_col_sel_r & ~cas_act);
    wire refresh_enable_ras_term = ~(state_nxt == `FDC_S_RRAS);
    wire acc_col_term = ~(state_nxt == `FDC_S_ACOL);
    wire ras_n_nxt = row_strobe_comb_term & refresh_enable_ras_term & acc_col_term;
    wire cas_n_nxt = ~(state_nxt == `FDC_S_ACOL) &
        ~(state_nxt == `FDC_S_RCAS) & ~(state_nxt == `FDC_S_RRAS);

    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ras_n_r <= `FDC_ONE;
            cas_n_r <= `FDC_ONE;
            we_n_r <= `FDC_ONE;
            oe_n_r <= `FDC_ONE;
            row_col_sel_r <= `FDC_ONE;
            access_enable_secondary_r <= `FDC_ZERO;
        end else if (init_clr) begin
            ras_n_r <= `FDC_ONE;
            cas_n_r <= `FDC_ONE;
            we_n_r <= `FDC_ONE;
            oe_n_r <= `FDC_ONE;
            row_col_sel_r <= `FDC_ONE;
            access_enable_secondary_r <= `FDC_ZERO;
        end else begin
            // Inactive state is the set value of the flop
            ras_n_r <= ras_n_nxt;
            cas_n_r <= cas_n_nxt;
            we_n_r <= ~((state_nxt == `FDC_S_ACOL) & wr_sel_r);
            oe_n_r <= ~((state_nxt == `FDC_S_ACOL) & rd_sel_r);
            row_col_sel_r <= ~(state_nxt == `FDC_S_ACOL);
            if (acc_start) begin
                access_enable_secondary_r <= `FDC_ONE;
            end else if (ras_n_nxt & ras_n_r) begin
                // RAS released and staying high ends the access window
                access_enable_secondary_r <= `FDC_ZERO;
            end
        end
    end

    // ----------------------------------------
    // Pointers and status counter
    // ----------------------------------------
    wire access_enable = acc_done & access_enable_secondary_r;

    fdc_cnt16 u_read_ptr (
        .mclk(mclk),
        .reset_n(reset_n),
        .clr(init_clr),
        .step(access_enable & rd_sel_r),
        .up(`FDC_ONE),
        .count_r(read_ptr)
    );

    fdc_cnt16 u_write_ptr (
        .mclk(mclk),
        .reset_n(reset_n),
        .clr(init_clr),
        .step(access_enable & wr_sel_r),
        .up(`FDC_ONE),
        .count_r(write_ptr)
    );

    fdc_cnt16 u_status (
        .mclk(mclk),
        .reset_n(reset_n),
        .clr(init_clr),
        .step(access_enable),
        .up(wr_sel_r),
        .count_r(status_cnt)
    );

    // ----------------------------------------
    // Address path
    // ----------------------------------------
    wire [15:0] sel_ptr = rd_sel_r ? read_ptr : write_ptr;
    wire [7:0] row_addr = sel_ptr[`FDC_ROW_MSB:`FDC_ROW_LSB];
    wire [7:0] col_addr = sel_ptr[`FDC_COL_MSB:`FDC_COL_LSB];
    wire rcs_nxt = ~(state_nxt == `FDC_S_ACOL);

    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            dram_addr_r <= `FDC_ADR_RST;
        end else if (init_clr) begin
            dram_addr_r <= `FDC_ADR_RST;
        end else if (state_r == `FDC_S_AROW || state_r == `FDC_S_ARAS) begin
            // Registered so the pins change only on mclk
            dram_addr_r <= rcs_nxt ? row_addr : col_addr;
        end else if (acc_start) begin
            dram_addr_r <= (can_wr ? write_ptr[`FDC_ROW_MSB:`FDC_ROW_LSB] :
                read_ptr[`FDC_ROW_MSB:`FDC_ROW_LSB]);
        end
    end

    // ----------------------------------------
    // Flags and ready
    // ----------------------------------------
    assign flag_empty = (status_cnt == `FDC_PTR_RST);
    assign flag_full = (status_cnt == `FDC_PTR_ALL1);
    // Monitor only; nothing is blocked by it
    assign flag_half = status_cnt[`FDC_HALF_BIT];
    // Low through refresh and any access
    assign rdy_wr = idle & ~refresh_enable_go & ~flag_full & ~init_clr;
    assign rdy_rd = idle & ~refresh_enable_go & ~flag_empty & ~init_clr;

endmodule

// ---- hdl/fdc_map.vh ----
// Constants for the FIFO DRAM controller datapath.
// Assumes it is included by bare name from the design files.
`ifndef FDC_MAP_VH
`define FDC_MAP_VH

// ----------------------------------------
// Widths
// ----------------------------------------
`define FDC_PTR_W 16
`define FDC_ADR_W 8
`define FDC_ST_W 3

// ----------------------------------------
// Clock figures
// ----------------------------------------
`define FDC_MCLK_KHZ 50000
`define FDC_SYS_KHZ 5000
`define FDC_REFRESH_ENABLE_HZ 64000
`define FDC_REFRESH_ENABLE_NS 15600

// ----------------------------------------
// Reset values and fixed levels
// ----------------------------------------
`define FDC_PTR_RST 16'h0000
`define FDC_PTR_ALL1 16'hFFFF
`define FDC_ADR_RST 8'h00
`define FDC_ONE 1'b1
`define FDC_ZERO 1'b0

// ----------------------------------------
// Pointer field split
// ----------------------------------------
`define FDC_ROW_LSB 0
`define FDC_ROW_MSB 7
`define FDC_COL_LSB 8
`define FDC_COL_MSB 15
`define FDC_HALF_BIT 15

// ----------------------------------------
// Sequencer states
// ----------------------------------------
`define FDC_S_IDLE 3'h0
`define FDC_S_AROW 3'h1
`define FDC_S_ARAS 3'h2
`define FDC_S_ACOL 3'h3
`define FDC_S_AEND 3'h4
`define FDC_S_RCAS 3'h5
`define FDC_S_RRAS 3'h6
`define FDC_S_REND 3'h7

`endif

// ---- hdl/fdc_cnt16.v ----
// Sixteen-bit ripple-carry counter, up or down, one step per strobe.
// Assumes step and clear come from logic on mclk.
`timescale 1ns/1ps
`include "fdc_map.vh"

module fdc_cnt16 (
    input wire mclk,
    input wire reset_n,
    input wire clr,
    input wire step,
    input wire up,
    output reg [15:0] count_r
);

    reg [16:0] carry;
    reg [15:0] count_nxt;
    integer i;

    // ----------------------------------------
    // Carry chain, one term per bit
    // ----------------------------------------
    always @* begin
        carry[0] = step;
        for (i = 0; i < `FDC_PTR_W; i = i + 1) begin
            carry[i+1] = carry[i] & (up ? count_r[i] : ~count_r[i]);
        end
        count_nxt = count_r ^ carry[15:0];
    end

    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            count_r <= `FDC_PTR_RST;
        end else if (clr) begin
            count_r <= `FDC_PTR_RST;
        end else begin
            count_r <= count_nxt;
        end
    end

endmodule

// ---- verification/fdc_dram.sv ----
// DRAM array model: latches row and column, counts cycles.
// Assumes strobes and address come from fdc_ctrl.
`timescale 1ns/1ps
module fdc_dram (
    input wire ras_n,
    input wire cas_n,
    input wire we_n,
    input wire [7:0] addr,
    output reg [7:0] row,
    output reg [7:0] col,
    output reg wr,
    output integer acc_cnt,
    output integer ref_cnt
);
    // ----------------------------------------
    // Strobe decode
    // ----------------------------------------
    initial begin
        acc_cnt = 0;
        ref_cnt = 0;
    end
    always @(negedge ras_n) begin
        if (cas_n) row = addr;
    end
    // Small delay: column and write enable launch on the CAS edge
    always @(negedge cas_n) begin
        #1;
        if (ras_n) begin
            ref_cnt = ref_cnt + 1;
        end else begin
            col = addr;
            wr = !we_n;
            acc_cnt = acc_cnt + 1;
        end
    end
endmodule

// ---- verification/fdc_monitor.sv ----
// Checker for the FIFO DRAM controller pins.
// Assumes it is bound to fdc_ctrl and sees only its ports.
`timescale 1ns/1ps
module fdc_monitor (
    input wire mclk,
    input wire reset_n,
    input wire init_clr,
    input wire req_wr_n,
    input wire req_rd_n,
    input wire refresh_enable_req_n,
    input wire ras_n_r,
    input wire cas_n_r,
    input wire we_n_r,
    input wire oe_n_r,
    input wire [7:0] dram_addr_r,
    input wire rdy_wr,
    input wire rdy_rd,
    input wire flag_full,
    input wire flag_half,
    input wire flag_empty
);
    // ----------------------------------------
    // Strobe, address and flag relations
    // ----------------------------------------
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n || init_clr);
    property p_flags; flag_empty |-> !flag_full && !flag_half; endproperty
    a_flags: assert property (p_flags)
        else $error("empty with full or half");
    property p_rd_block; flag_empty |-> !rdy_rd; endproperty
    a_rd_block: assert property (p_rd_block)
        else $error("read ready while empty");
    property p_busy; !ras_n_r || !cas_n_r |-> !rdy_wr && !rdy_rd; endproperty
    a_busy: assert property (p_busy)
        else $error("ready during strobe");
    property p_ras_acc; $fell(ras_n_r) && cas_n_r |=> !ras_n_r && !cas_n_r
        ##1 ras_n_r && cas_n_r; endproperty
    a_ras_acc: assert property (p_ras_acc)
        else $error("access strobe order");
    property p_refresh_enable; $fell(cas_n_r) && ras_n_r |=> !ras_n_r && !cas_n_r
        ##1 ras_n_r && cas_n_r; endproperty
    a_refresh_enable: assert property (p_refresh_enable)
        else $error("refresh strobe order");
    property p_we; !we_n_r |-> !cas_n_r && !ras_n_r && oe_n_r; endproperty
    a_we: assert property (p_we)
        else $error("write enable outside column");
    property p_oe; !oe_n_r |-> !cas_n_r && !ras_n_r && we_n_r; endproperty
    a_oe: assert property (p_oe)
        else $error("output enable outside column");
    property p_empty; $rose(flag_empty) && !$past(init_clr)
        |-> !$past(oe_n_r, 2); endproperty
    a_empty: assert property (p_empty)
        else $error("empty without read");
    property p_addr; $fell(cas_n_r) && ras_n_r |-> $stable(dram_addr_r);
    endproperty
    a_addr: assert property (p_addr)
        else $error("address moved in refresh");
endmodule
bind fdc_ctrl fdc_monitor u_mon (.mclk(mclk), .reset_n(reset_n),
    .init_clr(init_clr), .req_wr_n(req_wr_n), .req_rd_n(req_rd_n),
    .refresh_enable_req_n(refresh_enable_req_n), .ras_n_r(ras_n_r), .cas_n_r(cas_n_r),
    .we_n_r(we_n_r), .oe_n_r(oe_n_r), .dram_addr_r(dram_addr_r),
    .rdy_wr(rdy_wr), .rdy_rd(rdy_rd), .flag_full(flag_full),
    .flag_half(flag_half), .flag_empty(flag_empty));

// ---- verification/testbench.sv ----
// Self-checking bench for fdc_ctrl against a FIFO pointer model.
// Assumes fdc_ctrl, fdc_dram and fdc_monitor are compiled first.
`timescale 1ns/1ps
module testbench;
    logic mclk = 0;
    logic reset_n = 0;
    logic init_clr = 0;
    logic req_wr_n = 1;
    logic req_rd_n = 1;
    logic refresh_enable_req_n = 1;
    wire ras_n_r, cas_n_r, we_n_r, oe_n_r, rdy_wr, rdy_rd, wr;
    wire flag_full, flag_half, flag_empty;
    wire [7:0] dram_addr_r, row, col;
    integer acc_cnt, ref_cnt, i, n;
    integer bad_count = 0, checks = 0, wptr = 0, rptr = 0, fill = 0;
    integer falls = 0, rdiv = 0;
    always #10 mclk = ~mclk;
    fdc_ctrl DUT (.mclk(mclk), .reset_n(reset_n), .init_clr(init_clr),
        .req_wr_n(req_wr_n), .req_rd_n(req_rd_n), .refresh_enable_req_n(refresh_enable_req_n),
        .ras_n_r(ras_n_r), .cas_n_r(cas_n_r), .we_n_r(we_n_r),
        .oe_n_r(oe_n_r), .dram_addr_r(dram_addr_r), .rdy_wr(rdy_wr),
        .rdy_rd(rdy_rd), .flag_full(flag_full), .flag_half(flag_half),
        .flag_empty(flag_empty));
    fdc_dram u_dram (.ras_n(ras_n_r), .cas_n(cas_n_r), .we_n(we_n_r),
        .addr(dram_addr_r), .row(row), .col(col), .wr(wr),
        .acc_cnt(acc_cnt), .ref_cnt(ref_cnt));
    // ----------------------------------------
    // Refresh clock, free running, and tasks
    // ----------------------------------------
    always @(negedge mclk) begin
        rdiv = rdiv + 1;
        if (rdiv == 390) begin
            rdiv = 0;
            refresh_enable_req_n = ~refresh_enable_req_n;
            if (!refresh_enable_req_n) falls = falls + 1;
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks = checks + 1;
        if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task give_verdict;
        if (bad_count == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Release once RAS falls so the level is not taken twice
    task automatic access(input bit do_wr);
        integer k, a0, p;
        a0 = acc_cnt;
        p = do_wr ? wptr : rptr;
        if (do_wr) req_wr_n = 0;
        else req_rd_n = 0;
        for (k = 0; k < 3000 && !(ras_n_r === 0 && cas_n_r === 1); k++)
            @(negedge mclk);
        check(16'(k < 3000), 16'h0001);
        req_wr_n = 1;
        req_rd_n = 1;
        for (k = 0; k < 3000 && rdy_wr !== 1; k++) @(negedge mclk);
        check(16'(k < 3000), 16'h0001);
        if (do_wr) wptr = wptr + 1;
        else rptr = rptr + 1;
        fill = do_wr ? fill + 1 : fill - 1;
        check(16'(acc_cnt - a0), 16'h0001);
        check({col, row}, 16'(p));
        check(16'(wr), 16'(do_wr));
        check({flag_full, flag_half, flag_empty},
            {fill == 65535, fill >= 32768, fill == 0});
    endtask
    initial begin
        #1000000;
        bad_count = bad_count + 1;
        give_verdict;
    end
    initial begin
        n = $urandom(32'h1907);
        repeat (2) @(negedge mclk);
        reset_n = 1;
        repeat (2) @(negedge mclk);
        check({ras_n_r, cas_n_r, we_n_r, oe_n_r, flag_empty}, 16'h001f);
        req_rd_n = 0;
        repeat (12) @(negedge mclk);
        check(16'(acc_cnt), 16'h0000);
        check(16'(rdy_rd), 16'h0000);
        req_rd_n = 1;
        repeat (3) @(negedge mclk);
        for (i = 0; i < 800; i++) access(fill == 0 || $urandom % 3 != 0);
        while (fill > 0) access(0);
        wait (rdiv == 100);
        check(16'(ref_cnt), 16'(falls));
        access(1);
        access(1);
        init_clr = 1;
        @(negedge mclk);
        init_clr = 0;
        wptr = 0;
        rptr = 0;
        fill = 0;
        repeat (3) @(negedge mclk);
        check({ras_n_r, cas_n_r, flag_empty}, 16'h0007);
        access(1);
        access(0);
        give_verdict;
    end
endmodule
